// ### rsp_uart.sv
// rs232 port with rts/cts character handshake and wishbone registers
// Behaviour
// - rts high when receive buffer full or terminator held, else low
// - four-character receive buffer; overflow chars dropped
// - rts low again once a slot frees
// - terminator raises rts until validation done
// - cts low and char waiting starts transmit
// - cts high blocks start; line idles mark
// - cts change mid-character never aborts it
// - ten selectable rates from 75 to 19200
// - reset returns rate to 9600
// - one rate serves transmit and receive
// - frame is start, eight data, stop
// - xon and xoff get no special treatment
// - talk-only mode discards every received character
// - talk-only results go out the transmitter
// - cr or lf ends line; lf after cr dropped
`timescale 1ns/10ps
module rsp_uart
  import rsp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  input  wire logic        rxd_i,
  input  wire logic        cts_n_i,
  output logic             txd_o,
  output logic             rts_n_o,
  output logic             talk_only_o
);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ---------------- pin synchronisers
  logic rxd_s1, rxd_s2, cts_s1, cts_s2;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
      cts_s1 <= 1'b1;
      cts_s2 <= 1'b1;
    end else begin
      rxd_s1 <= rxd_i;
      rxd_s2 <= rxd_s1;
      cts_s1 <= cts_n_i;
      cts_s2 <= cts_s1;
    end
  end

  // ---------------- wishbone slave
  logic [3:0]  baud_reg;
  logic        talk_reg;
  logic        tick;
  wire         req     = cyc_i & stb_i;
  wire         commit  = req & ack_o;
  wire         wr_lo   = commit & we_i & sel_i[0];
  wire         wr_ctrl = wr_lo & (adr_i == REG_CTRL);
  wire         wr_stat = wr_lo & (adr_i == REG_STATUS);
  wire         wr_tx   = wr_lo & (adr_i == REG_TXDATA);
  wire         wr_done = wr_lo & (adr_i == REG_CMD_DONE);
  wire         rd_rx   = commit & ~we_i & (adr_i == REG_RXDATA);
  logic [31:0] rd_mux;
  rsp_status_t stat;

  // one rate register feeds a single tick for both directions
  rsp_tick_gen u_tick (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .baud_sel_i (baud_reg),
    .tick_o     (tick)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      baud_reg <= BAUD_9600;
      talk_reg <= TALK_RST;
    end else if (wr_ctrl) begin
      // out-of-range codes are refused so the rate stays legal
      if (dat_i[CTRL_BAUD_LSB +: 4] <= BAUD_MAX)
        baud_reg <= dat_i[CTRL_BAUD_LSB +: 4];
      talk_reg <= dat_i[CTRL_TALK_BIT];
    end
  end

  // ---------------- receive buffer
  logic [7:0]     rx_mem [RX_DEPTH];
  logic [1:0]     rx_wp, rx_rp;
  logic [2:0]     cnt_reg;
  logic [2:0]     cnt_next;
  logic           hold_reg, hold_next;
  logic           ovf_reg, last_cr_reg;
  logic           rx_done;
  logic [7:0]     rx_byte;
  wire            rx_full  = (cnt_reg == 3'(RX_DEPTH));
  wire            is_term  = (rx_byte == CHR_CR) | (rx_byte == CHR_LF);
  wire            lf_drop  = (rx_byte == CHR_LF) & last_cr_reg;
  wire            take     = rx_done & ~talk_reg & ~lf_drop;
  wire            push     = take & ~rx_full;
  wire            pop      = rd_rx & (cnt_reg != 3'h0);
  wire            term_in  = push & is_term;

  assign cnt_next  = cnt_reg + {2'b00, push} - {2'b00, pop};
  assign hold_next = term_in | (hold_reg & ~wr_done);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_wp       <= '0;
      rx_rp       <= '0;
      cnt_reg     <= '0;
      hold_reg    <= 1'b0;
      ovf_reg     <= 1'b0;
      last_cr_reg <= 1'b0;
      rts_n_o     <= 1'b0;
    end else begin
      if (push) begin
        rx_mem[rx_wp] <= rx_byte;
        rx_wp         <= rx_wp + 2'h1;
      end
      if (pop)
        rx_rp <= rx_rp + 2'h1;
      cnt_reg  <= cnt_next;
      hold_reg <= hold_next;
      // a new overflow beats a clear in the same cycle
      ovf_reg  <= (take & rx_full) | (ovf_reg & ~(wr_stat & dat_i[STAT_OVF_BIT]));
      if (rx_done & ~talk_reg)
        last_cr_reg <= (rx_byte == CHR_CR);
      rts_n_o  <= (cnt_next == 3'(RX_DEPTH)) | hold_next;
    end
  end

  // ---------------- receiver
  rsp_ser_state_t rx_state;
  logic [3:0]     rx_tc;
  logic [2:0]     rx_bit;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state <= SER_IDLE;
      rx_tc    <= '0;
      rx_bit   <= '0;
      rx_byte  <= '0;
      rx_done  <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      case (rx_state)
        SER_IDLE: begin
          rx_tc <= '0;
          if (!rxd_s2)
            rx_state <= SER_START;
        end
        SER_START: begin
          if (tick) begin
            rx_tc <= rx_tc + 4'h1;
            if (rx_tc == TICK_MID) begin
              // a glitch shorter than half a bit is not a start
              rx_tc    <= '0;
              rx_bit   <= '0;
              rx_state <= rxd_s2 ? SER_IDLE : SER_DATA;
            end
          end
        end
        SER_DATA: begin
          if (tick) begin
            rx_tc <= rx_tc + 4'h1;
            if (rx_tc == TICK_LAST) begin
              rx_byte <= {rxd_s2, rx_byte[7:1]};
              rx_bit  <= rx_bit + 3'h1;
              if (rx_bit == BIT_LAST)
                rx_state <= SER_STOP;
            end
          end
        end
        SER_STOP: begin
          if (tick) begin
            rx_tc <= rx_tc + 4'h1;
            if (rx_tc == TICK_LAST) begin
              rx_done  <= rxd_s2;
              rx_state <= SER_IDLE;
            end
          end
        end
        default: rx_state <= SER_IDLE;
      endcase
    end
  end

  // ---------------- transmitter
  rsp_ser_state_t tx_state;
  logic [3:0]     tx_tc;
  logic [2:0]     tx_bit;
  logic [7:0]     tx_hold, tx_sh;
  logic           tx_full;
  wire            tx_go = tx_full & ~cts_s2 & (tx_state == SER_IDLE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state <= SER_IDLE;
      tx_tc    <= '0;
      tx_bit   <= '0;
      tx_hold  <= '0;
      tx_sh    <= '0;
      tx_full  <= 1'b0;
      txd_o    <= 1'b1;
    end else begin
      // software writes measurement text here in talk-only mode too
      if (wr_tx & ~tx_full) begin
        tx_hold <= dat_i[7:0];
        tx_full <= 1'b1;
      end else if (tx_go) begin
        tx_full <= 1'b0;
      end
      txd_o <= (tx_state == SER_START) ? 1'b0 :
               (tx_state == SER_DATA)  ? tx_sh[0] : 1'b1;
      case (tx_state)
        SER_IDLE: begin
          tx_tc  <= '0;
          tx_bit <= '0;
          if (tx_go) begin
            tx_sh    <= tx_hold;
            tx_state <= SER_START;
          end
        end
        SER_START: begin
          if (tick) begin
            tx_tc <= tx_tc + 4'h1;
            if (tx_tc == TICK_LAST)
              tx_state <= SER_DATA;
          end
        end
        SER_DATA: begin
          if (tick) begin
            tx_tc <= tx_tc + 4'h1;
            if (tx_tc == TICK_LAST) begin
              tx_sh  <= {1'b0, tx_sh[7:1]};
              tx_bit <= tx_bit + 3'h1;
              if (tx_bit == BIT_LAST)
                tx_state <= SER_STOP;
            end
          end
        end
        SER_STOP: begin
          if (tick) begin
            tx_tc <= tx_tc + 4'h1;
            if (tx_tc == TICK_LAST)
              tx_state <= SER_IDLE;
          end
        end
        default: tx_state <= SER_IDLE;
      endcase
    end
  end

  // ---------------- read mux and answer
  assign stat = '{rts_busy: rts_n_o, overflow: ovf_reg, hold: hold_reg,
                  tx_busy: (tx_state != SER_IDLE), tx_full: tx_full, rx_count: cnt_reg};

  assign rd_mux = (adr_i == REG_CTRL)   ? {27'h0, talk_reg, baud_reg} :
                  (adr_i == REG_STATUS) ? {24'h0, stat} :
                  (adr_i == REG_RXDATA) ? {23'h0, (cnt_reg != 3'h0), rx_mem[rx_rp]} :
                  32'h0;

  // answer one cycle after the request; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o       <= 1'b0;
      dat_o       <= '0;
      talk_only_o <= 1'b0;
    end else begin
      ack_o       <= req & ~ack_o;
      talk_only_o <= talk_reg;
      if (req & ~ack_o)
        dat_o <= rd_mux;
    end
  end

  // ---------------- checks
  sequence s_term_taken;
    term_in;
  endsequence

  sequence s_done_seen;
    hold_reg && wr_done && !term_in;
  endsequence

  a_rts_when_full:   assert property (rx_full |-> rts_n_o)
    else $error("rts low while receive buffer full");
  a_buffer_bound:    assert property (cnt_reg <= 3'(RX_DEPTH))
    else $error("receive buffer count above depth");
  a_rts_slot_free:   assert property (!rx_full && !hold_reg |-> !rts_n_o)
    else $error("rts high with free slot and no hold");
  a_term_holds_rts:  assert property (s_term_taken |=> hold_reg && rts_n_o)
    else $error("terminator did not raise rts");
  a_hold_release:    assert property (s_done_seen |=> !hold_reg)
    else $error("hold not released after validation");
  a_start_needs_cts: assert property ($rose(tx_state == SER_START) |-> $past(!cts_s2))
    else $error("transmit started while cts negated");
  a_idle_mark:       assert property ((tx_state == SER_IDLE) [*2] |-> txd_o)
    else $error("transmit line not at mark while idle");
  a_no_abort_char:   assert property (tx_state == SER_DATA |=> tx_state inside {SER_DATA, SER_STOP})
    else $error("character aborted mid-transfer");
  a_talk_discards:   assert property (talk_reg && rx_done && !pop |=> cnt_reg == $past(cnt_reg))
    else $error("character stored in talk-only mode");
  a_lf_after_cr:     assert property (rx_done && lf_drop |-> !push)
    else $error("lf after cr was stored");
  a_reset_rate:      assert property (disable iff (1'b0) rst_i |=> baud_reg == BAUD_9600)
    else $error("rate not 9600 after reset");

endmodule : rsp_uart

// ### rsp_pkg.sv
// shared constants, register map and types of the rs232 port
package rsp_pkg;

  localparam int          CLK_HZ        = 25_000_000;
  localparam int          OVS           = 16;
  localparam int          RX_DEPTH      = 4;
  localparam int          BAUD_W        = 4;
  localparam int          DIV_W         = 16;

  // register byte offsets
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_TXDATA    = 8'h08;
  localparam logic [7:0]  REG_RXDATA    = 8'h0c;
  localparam logic [7:0]  REG_CMD_DONE  = 8'h10;

  // control field positions
  localparam int          CTRL_BAUD_LSB = 0;
  localparam int          CTRL_TALK_BIT = 4;

  // status field positions
  localparam int          STAT_OVF_BIT  = 6;

  // rx data field positions
  localparam int          RXD_VALID_BIT = 8;

  // reset values and highest rate code
  localparam logic [3:0]  BAUD_9600     = 4'h8;
  localparam logic [3:0]  BAUD_MAX      = 4'h9;
  localparam logic        TALK_RST      = 1'b0;

  // counts of oversample ticks and data bits
  localparam logic [3:0]  TICK_MID      = 4'h7;
  localparam logic [3:0]  TICK_LAST     = 4'hf;
  localparam logic [2:0]  BIT_LAST      = 3'h7;

  // terminators
  localparam logic [7:0]  CHR_CR        = 8'h0d;
  localparam logic [7:0]  CHR_LF        = 8'h0a;

  typedef enum logic [3:0] {
    SER_IDLE  = 4'b0001,
    SER_START = 4'b0010,
    SER_DATA  = 4'b0100,
    SER_STOP  = 4'b1000
  } rsp_ser_state_t;

  typedef struct packed {
    logic       rts_busy;
    logic       overflow;
    logic       hold;
    logic       tx_busy;
    logic       tx_full;
    logic [2:0] rx_count;
  } rsp_status_t;

  function automatic int rsp_rate(input logic [3:0] sel);
    case (sel)
      4'h0:    rsp_rate = 75;
      4'h1:    rsp_rate = 110;
      4'h2:    rsp_rate = 150;
      4'h3:    rsp_rate = 300;
      4'h4:    rsp_rate = 600;
      4'h5:    rsp_rate = 1200;
      4'h6:    rsp_rate = 2400;
      4'h7:    rsp_rate = 4800;
      4'h9:    rsp_rate = 19200;
      default: rsp_rate = 9600;
    endcase
  endfunction : rsp_rate

  // clock cycles per oversample tick, rounded to nearest
  function automatic logic [15:0] rsp_div(input logic [3:0] sel);
    int r;
    r       = rsp_rate(sel);
    rsp_div = 16'((CLK_HZ + (OVS * r) / 2) / (OVS * r));
  endfunction : rsp_div

endpackage : rsp_pkg

// ### rsp_tick_gen.sv
// oversample tick generator shared by transmitter and receiver
`timescale 1ns/10ps
module rsp_tick_gen
  import rsp_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [BAUD_W-1:0] baud_sel_i,
  output logic                   tick_o
);

  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] cnt_next;
  logic [DIV_W-1:0] div;
  wire              wrap;

  assign div      = rsp_div(baud_sel_i);
  assign wrap     = (cnt_reg >= div - 16'h0001);
  assign cnt_next = wrap ? 16'h0000 : cnt_reg + 16'h0001;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      tick_o  <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_o  <= wrap;
    end
  end

endmodule : rsp_tick_gen

// ### rsp_host_model.sv
// behavioural host serial port: sends on rxd, captures from txd
`timescale 1ns/10ps
module rsp_host_model #(
  parameter int BIT_CLKS = 1296
) (
  input  wire logic       clk_i,
  input  wire logic       txd_i,
  input  wire logic       rts_n_i,
  output logic            rxd_o,
  output logic [7:0]      got_o,
  output int              got_cnt_o
);

  initial begin
    rxd_o     = 1'b1;
    got_o     = 8'h00;
    got_cnt_o = 0;
  end

  // one bit time serves both directions
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    // honour the handshake before every start bit
    while (rts_n_i !== 1'b0) @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      rxd_o <= f[i];
      repeat (BIT_CLKS) @(posedge clk_i);
    end
  endtask : send

  // sample each bit mid-way; a bad stop bit drops the frame
  always begin : rx_side
    logic [7:0] b;
    @(negedge txd_i);
    repeat (BIT_CLKS / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk_i);
      b[i] = txd_i;
    end
    repeat (BIT_CLKS) @(posedge clk_i);
    if (txd_i === 1'b1) begin
      got_o     = b;
      got_cnt_o = got_cnt_o + 1;
    end
  end

endmodule : rsp_host_model

// ### rsp_uart_test.sv
// self-checking bench of the rs232 port over wishbone
`timescale 1ns/10ps
module rsp_uart_test;
  import rsp_pkg::*;

  logic        clk_i, rst_i, cyc, stb, we, cts_n, loop;
  logic [3:0]  sel, bsel;
  logic [7:0]  adr, got;
  logic [31:0] dat, dat_o, q;
  logic        ack_o, rxd, txd_o, rts_n_o, talk_only_o;
  int          mismatches, total_checks, cycles, got_cnt;

  rsp_uart rsp_uart_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
    .dat_o(dat_o), .ack_o(ack_o), .rxd_i(rxd), .cts_n_i(cts_n),
    .txd_o(txd_o), .rts_n_o(rts_n_o), .talk_only_o(talk_only_o)
  );

  // 19200 baud gives 81 clocks per tick, 16 ticks per bit
  rsp_host_model #(.BIT_CLKS(1296)) rsp_host_model_inst (
    .clk_i(clk_i), .txd_i(txd_o), .rts_n_i(rts_n_o),
    .rxd_o(rxd), .got_o(got), .got_cnt_o(got_cnt)
  );

  // three-wire hookup: clear-to-send simply follows request-to-send
  always @(posedge clk_i) begin
    if (loop)
      cts_n <= rts_n_o;
  end

  initial clk_i = 1'b0;
  always #20 clk_i = ~clk_i;

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  // seven frames of about 13000 clocks each, plus margin
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 99000) begin
      mismatches++;
      test_done;
    end
  end

  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask : check

  // waits for ack however long it takes; only the bench timeout ends a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    sel <= bsel;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : settle

  initial begin
    {cyc, stb, we, adr, dat} = '0;
    sel  = 4'hf;
    bsel = 4'hf;
    loop = 1'b0;
    {mismatches, total_checks, cycles} = '0;
    cts_n = 1'b1;
    rst_i = 1'b1;
    settle(5);
    rst_i <= 1'b0;
    wb(0, REG_CTRL, 0);   check("ctrl", 32'h8, q);
    wb(0, REG_STATUS, 0); check("status", 32'h0, q);
    wb(0, 8'h14, 0);      check("unmapped", 32'h0, q);
    wb(1, REG_CTRL, 32'h9);
    wb(1, REG_CTRL, 32'hf);
    // a write without the low byte lane must leave the register alone
    bsel <= 4'he;
    wb(1, REG_CTRL, 32'h13);
    bsel <= 4'hf;
    wb(0, REG_CTRL, 0);   check("rate", 32'h9, q);
    $display("test regs done");
    wb(1, REG_TXDATA, 32'ha5);
    settle(300);
    check("held txd", 1, txd_o);
    check("held cnt", 0, got_cnt);
    cts_n <= 1'b0;
    settle(2600);
    // raise clear-to-send again in mid-frame
    cts_n <= 1'b1;
    for (int n = 0; n < 20000 && got_cnt == 0; n++) settle(1);
    check("tx char", 32'ha5, got);
    $display("test tx done");
    rsp_host_model_inst.send(8'h61);
    rsp_host_model_inst.send(CHR_CR);
    settle(20);
    check("rts term", 1, rts_n_o);
    wb(0, REG_STATUS, 0); check("hold", 32'ha2, q);
    wb(1, REG_CMD_DONE, 1);
    settle(3);
    check("rts done", 0, rts_n_o);
    rsp_host_model_inst.send(CHR_LF);
    // flow-control bytes are plain data here
    rsp_host_model_inst.send(8'h13);
    rsp_host_model_inst.send(8'h11);
    settle(20);
    check("rts full", 1, rts_n_o);
    // with the loop closed a full buffer also blocks our own transmit
    loop <= 1'b1;
    wb(1, REG_TXDATA, 32'h5a);
    settle(10);
    wb(0, REG_STATUS, 0); check("loop hold", 32'h8c, q);
    wb(0, REG_RXDATA, 0); check("rx 0", 32'h161, q);
    settle(3);
    check("rts free", 0, rts_n_o);
    wb(0, REG_RXDATA, 0); check("rx 1", 32'h10d, q);
    wb(0, REG_RXDATA, 0); check("rx 2", 32'h113, q);
    $display("test rx done");
    wb(1, REG_CTRL, 32'h19);
    settle(3);
    check("talk", 1, talk_only_o);
    rsp_host_model_inst.send(8'h41);
    settle(200);
    wb(0, REG_STATUS, 0); check("talk rx", 32'h1, q);
    check("loop char", 32'h5a, got);
    check("loop count", 2, got_cnt);
    $display("test talk done");
    test_done;
  end

endmodule : rsp_uart_test
